// File: src/baud_timing_pkg.sv
// Package of constants and types for the baud rate and frame timing block
package baud_timing_pkg;
  // ============================================================
  // Field layout
  localparam int SEL_W = 4;
  localparam int DIV_W = 8;
  localparam int PRE_W = 7;
  // ============================================================
  // Division value limits and reset values
  localparam logic [7:0] DIV_MIN = 8'h08;
  localparam logic [7:0] DIV_MAX = 8'hff;
  localparam logic [7:0] DIV_RESET = 8'hff;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'h6;
  // ============================================================
  // Frame timing
  localparam logic [3:0] FRAME_BITS = 4'hb;
  localparam logic [3:0] STOP_STRETCH_CLKS = 4'h2;
  localparam logic [3:0] LATCH_MARGIN_CLKS = 4'h2;

  typedef struct packed {
    logic [3:0] base_clock_select;
    logic [7:0] division_value;
  } baud_cfg_t;

  typedef struct packed {
    logic bit_tick;
    logic frame_done;
    logic busy;
  } tx_timing_t;

  typedef struct packed {
    logic sample_tick;
    logic frame_done;
    logic busy;
    logic [3:0] bit_index;
  } rx_timing_t;
endpackage : baud_timing_pkg

// File: src/base_clock_prescaler.sv
// Prescaler producing the base clock enable from the system clock
`timescale 1ns/10ps
module base_clock_prescaler
  import baud_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic enable,
  input wire logic [SEL_W-1:0] base_clock_select,
  // Base clock enable
  output logic base_tick
);
  typedef struct packed {
    logic [PRE_W-1:0] count;
    logic tick;
  } pre_state_t;

  pre_state_t state_reg;
  pre_state_t state_next;
  logic [PRE_W-1:0] mask;

  // ============================================================
  // Code n divides by two to the power n
  always_comb begin
    mask = PRE_W'((8'h01 << base_clock_select) - 8'h01);
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!enable) begin
      state_next.count = '0;
    end else begin
      state_next.count = (state_reg.count + 1'b1) & mask;
      state_next.tick = ((state_reg.count & mask) == mask);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign base_tick = state_reg.tick;
endmodule : base_clock_prescaler

// File: src/uart_baud_frame_timing.sv
// Baud rate generator with transmit and receive frame timing counters
`timescale 1ns/10ps
// Behaviour
// - The division value k ranges 8 to 255 and the bit counters time each bit from it.
// - One bit lasts 2*k base clocks, so the bit rate is the base clock over 2k.
// - A four-bit select field picks the base clock, codes 0 to 6 in use.
// - With a 10 MHz base, code 2 with k 130 gives about 9615 bps and code 1 with k 80 gives 31250 bps.
// - After a start bit the receive counter places each latch point, with a two base clock margin.
// - An 11-bit frame is received when its stop bit sample still meets the latch timing.
// - Back-to-back frames lengthen the stop bit by two base clocks.
// - The receive timing restarts at each start bit detected while the receiver is idle; a start bit seen while busy is ignored.
module uart_baud_frame_timing
  import baud_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Configuration
  input wire logic power_on,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire baud_timing_pkg::baud_cfg_t cfg,
  // Transmit control
  input wire logic tx_start,
  input wire logic tx_more,
  // Receive control
  input wire logic rx_start_detect,
  // Timing outputs
  output baud_timing_pkg::tx_timing_t tx_timing,
  output baud_timing_pkg::rx_timing_t rx_timing,
  output logic base_tick
);
  import baud_timing_pkg::*;

  typedef struct packed {
    logic [DIV_W:0] tx_cnt;
    logic [3:0] tx_bit;
    logic tx_busy;
    logic tx_stretch;
    logic [3:0] tx_extra;
    logic [DIV_W:0] rx_cnt;
    logic [3:0] rx_bit;
    logic rx_busy;
    logic [7:0] div_live;
    tx_timing_t tx_out;
    rx_timing_t rx_out;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [DIV_W:0] bit_len;
  logic [DIV_W:0] half_len;
  logic tx_bit_end;
  logic tx_last_bit;
  logic tx_stretch_end;
  logic rx_bit_end;
  logic rx_latch;
  logic rx_last_bit;

  // ============================================================
  // Helper functions
  // Clamp keeps a bad divisor from shortening bits below the allowed floor
  function automatic logic [7:0] clamp_div(input logic [7:0] k);
    clamp_div = (k < DIV_MIN) ? DIV_MIN : k;
  endfunction : clamp_div

  function automatic logic is_bit_end(input logic [DIV_W:0] cnt, input logic [DIV_W:0] len);
    is_bit_end = (cnt == len - 1'b1);
  endfunction : is_bit_end

  function automatic logic is_last_bit(input logic [3:0] idx);
    is_last_bit = (idx == FRAME_BITS - 4'h1);
  endfunction : is_last_bit

  // ============================================================
  // Base clock prescaler
  base_clock_prescaler u_pre (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(power_on),
    .base_clock_select(cfg.base_clock_select),
    .base_tick(base_tick)
  );

  // ============================================================
  // Bit timing
  always_comb begin
    bit_len = {state_reg.div_live, 1'b0};
    half_len = {1'b0, state_reg.div_live} - {5'h00, LATCH_MARGIN_CLKS};
    tx_bit_end = is_bit_end(state_reg.tx_cnt, bit_len);
    tx_last_bit = is_last_bit(state_reg.tx_bit);
    tx_stretch_end = (state_reg.tx_extra == STOP_STRETCH_CLKS - 4'h1);
    rx_bit_end = is_bit_end(state_reg.rx_cnt, bit_len);
    rx_latch = (state_reg.rx_cnt == half_len);
    rx_last_bit = is_last_bit(state_reg.rx_bit);
    state_next = state_reg;
    state_next.tx_out.bit_tick = 1'b0;
    state_next.tx_out.frame_done = 1'b0;
    state_next.rx_out.sample_tick = 1'b0;
    state_next.rx_out.frame_done = 1'b0;
    state_next.div_live = clamp_div(cfg.division_value);
    // ============================================================
    // Transmit counter
    if (!power_on || !tx_enable) begin
      state_next.tx_cnt = '0;
      state_next.tx_bit = '0;
      state_next.tx_busy = 1'b0;
      state_next.tx_stretch = 1'b0;
      state_next.tx_extra = '0;
    end else if (!state_reg.tx_busy) begin
      if (tx_start) begin
        state_next.tx_busy = 1'b1;
        state_next.tx_cnt = '0;
        state_next.tx_bit = '0;
      end
    end else if (state_reg.tx_stretch) begin
      if (base_tick) begin
        state_next.tx_extra = state_reg.tx_extra + 4'h1;
        if (tx_stretch_end) begin
          state_next.tx_stretch = 1'b0;
          state_next.tx_extra = '0;
          state_next.tx_out.frame_done = 1'b1;
          state_next.tx_cnt = '0;
          state_next.tx_bit = '0;
        end
      end
    end else if (base_tick) begin
      state_next.tx_cnt = state_reg.tx_cnt + 1'b1;
      if (tx_bit_end) begin
        state_next.tx_cnt = '0;
        state_next.tx_out.bit_tick = 1'b1;
        state_next.tx_bit = state_reg.tx_bit + 4'h1;
        if (tx_last_bit) begin
          if (tx_more) begin
            state_next.tx_stretch = 1'b1;
          end else begin
            state_next.tx_out.frame_done = 1'b1;
            state_next.tx_busy = 1'b0;
            state_next.tx_bit = '0;
          end
        end
      end
    end
    // ============================================================
    // Receive counter
    if (!power_on || !rx_enable) begin
      state_next.rx_cnt = '0;
      state_next.rx_bit = '0;
      state_next.rx_busy = 1'b0;
    end else if (rx_start_detect && !state_reg.rx_busy) begin
      state_next.rx_cnt = '0;
      state_next.rx_bit = '0;
      state_next.rx_busy = 1'b1;
    end else if (state_reg.rx_busy && base_tick) begin
      state_next.rx_cnt = state_reg.rx_cnt + 1'b1;
      if (rx_latch) begin
        state_next.rx_out.sample_tick = 1'b1;
        state_next.rx_out.bit_index = state_reg.rx_bit;
        if (rx_last_bit) begin
          state_next.rx_out.frame_done = 1'b1;
          state_next.rx_busy = 1'b0;
          state_next.rx_bit = '0;
          state_next.rx_cnt = '0;
        end
      end
      if (rx_bit_end) begin
        state_next.rx_cnt = '0;
        state_next.rx_bit = state_reg.rx_bit + 4'h1;
      end
    end
    // ============================================================
    // Busy follows the next state so it rises with the first counted cycle
    state_next.tx_out.busy = state_next.tx_busy;
    state_next.rx_out.busy = state_next.rx_busy;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
      state_reg.div_live <= DIV_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tx_timing = state_reg.tx_out;
  assign rx_timing = state_reg.rx_out;
endmodule : uart_baud_frame_timing

// File: dv/uart_baud_frame_timing_asserts.sv
// Port timing checker for the baud and frame timing block
`timescale 1ns/10ps
module uart_baud_frame_timing_asserts
  import baud_timing_pkg::*;
(
  // Clock, reset and controls
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic power_on,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire baud_timing_pkg::baud_cfg_t cfg,
  input wire logic tx_start,
  input wire logic tx_more,
  // Timing outputs
  input wire baud_timing_pkg::tx_timing_t tx_timing,
  input wire baud_timing_pkg::rx_timing_t rx_timing,
  input wire logic base_tick
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_start; tx_start && power_on && tx_enable && !tx_timing.busy |=> tx_timing.busy; endproperty
  a_start: assert property (p_start) else $error("tx start not taken");
  property p_sel0; (power_on && cfg.base_clock_select == 4'h0) [*3] |-> base_tick; endproperty
  a_sel0: assert property (p_sel0) else $error("code 0 base tick missing");
  // Shortest bit is 16 cycles, so eight quiet cycles hold for every setting
  property p_tx_gap; tx_timing.bit_tick |=> (!tx_timing.bit_tick) [*8]; endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("tx bit too short");
  property p_rx_gap; rx_timing.sample_tick |=> (!rx_timing.sample_tick) [*8]; endproperty
  a_rx_gap: assert property (p_rx_gap) else $error("rx latch too close");
  property p_rx_done; rx_timing.frame_done |-> rx_timing.bit_index == 4'ha; endproperty
  a_rx_done: assert property (p_rx_done) else $error("rx frame end not at bit 10");
  property p_txoff; !tx_enable |=> !tx_timing.busy && !tx_timing.bit_tick; endproperty
  a_txoff: assert property (p_txoff) else $error("tx counter not cleared");
  property p_rxoff; !rx_enable |=> !rx_timing.busy && !rx_timing.sample_tick; endproperty
  a_rxoff: assert property (p_rxoff) else $error("rx counter not cleared");
  property p_pwroff; !power_on |=> !base_tick && !tx_timing.busy; endproperty
  a_pwroff: assert property (p_pwroff) else $error("base clock runs while off");
  c_tx: cover property (tx_timing.frame_done);
  c_b2b: cover property (tx_timing.frame_done && tx_more);
  c_rx: cover property (rx_timing.frame_done);
endmodule : uart_baud_frame_timing_asserts
bind uart_baud_frame_timing uart_baud_frame_timing_asserts u_chk (.*);

// File: dv/remote_sender.sv
// Remote sender model that opens a frame every so many cycles
`timescale 1ns/10ps
module remote_sender (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic send,
  input wire logic [15:0] spacing,
  // Start bit seen by the block
  output logic rx_start_detect
);
  logic [15:0] cnt_reg;
  // Spacing is the sender's own frame rate, stretched stop included
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 16'h0000;
      rx_start_detect <= 1'b0;
    end else begin
      rx_start_detect <= send && cnt_reg == 16'h0000;
      cnt_reg <= (!send || cnt_reg == spacing - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
    end
  end
endmodule : remote_sender

// File: dv/uart_baud_frame_timing_tb_top.sv
// Testbench for the baud and frame timing block
`timescale 1ns/10ps
module uart_baud_frame_timing_tb_top;
  import baud_timing_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, power_on = 1'b0, tx_enable = 1'b0, rx_enable = 1'b0;
  logic tx_start = 1'b0, tx_more = 1'b0, send = 1'b0, base_tick, rx_start_detect;
  logic [15:0] spacing = 16'h0000;
  baud_cfg_t cfg = '0;
  tx_timing_t tx_timing;
  rx_timing_t rx_timing;
  int errors = 0, compares = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  uart_baud_frame_timing u_dut (.clk_sys(clk_sys), .resetn(resetn), .power_on(power_on),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .cfg(cfg), .tx_start(tx_start),
    .tx_more(tx_more), .rx_start_detect(rx_start_detect), .tx_timing(tx_timing),
    .rx_timing(rx_timing), .base_tick(base_tick));
  remote_sender u_far (.clk_sys(clk_sys), .resetn(resetn), .send(send), .spacing(spacing),
    .rx_start_detect(rx_start_detect));
  // ============================================================
  // Shared tasks
  task results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task wait_ev(input bit rx, output int t);
    int n;
    for (n = 0; n < 5000; n++) begin
      @(posedge clk_sys);
      #1;
      if (rx ? rx_timing.sample_tick === 1'b1 : tx_timing.bit_tick === 1'b1) break;
    end
    if (n == 5000) begin
      errors++;
      results();
    end
    t = cyc;
  endtask : wait_ev
  // ============================================================
  // Scenarios
  task t_rates;
    logic [3:0] sel_t [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0, 4'h0, 4'h2, 4'h1};
    int k_t [11] = '{8, 8, 8, 8, 8, 8, 8, 9, 5, 130, 80};
    int t0, t1, i, kk;
    for (i = 0; i < 11; i++) begin
      kk = k_t[i] < 8 ? 8 : k_t[i];
      cfg <= '{base_clock_select: sel_t[i], division_value: k_t[i][7:0]};
      tx_enable <= 1'b1;
      repeat (3) @(posedge clk_sys);
      tx_start <= 1'b1;
      wait_ev(0, t0);
      wait_ev(0, t1);
      chk("bit period", 16'(t1 - t0), 16'((2 * kk) << sel_t[i]));
      @(posedge clk_sys);
      tx_enable <= 1'b0;
      tx_start <= 1'b0;
      @(posedge clk_sys);
      #1 chk("tx busy off", 16'(tx_timing.busy), 16'h0000);
      @(posedge clk_sys);
    end
  endtask : t_rates
  task t_frames;
    int t [13];
    int i, n;
    cfg <= '{base_clock_select: 4'h0, division_value: 8'h08};
    tx_enable <= 1'b1;
    tx_more <= 1'b1;
    repeat (3) @(posedge clk_sys);
    tx_start <= 1'b1;
    for (i = 0; i < 13; i++) wait_ev(0, t[i]);
    chk("stop bit", 16'(t[10] - t[9]), 16'h0010);
    chk("stretched stop", 16'(t[11] - t[10]), 16'h0012);
    @(posedge clk_sys);
    tx_more <= 1'b0;
    tx_start <= 1'b0;
    n = 0;
    for (i = 0; i < 3000 && tx_timing.busy !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1 n += int'(tx_timing.bit_tick);
    end
    if (i == 3000) begin
      errors++;
      results();
    end
    chk("bits left in frame", 16'(n), 16'h0009);
    chk("tx frame end", 16'(tx_timing.frame_done), 16'h0001);
    @(posedge clk_sys);
  endtask : t_frames
  task t_rx;
    int t [22];
    int i;
    cfg <= '{base_clock_select: 4'h1, division_value: 8'h0a};
    rx_enable <= 1'b1;
    spacing <= 16'h01bc;
    repeat (3) @(posedge clk_sys);
    send <= 1'b1;
    for (i = 0; i < 22; i++) begin
      wait_ev(1, t[i]);
      chk("rx index", 16'(rx_timing.bit_index), 16'(i % 11));
      chk("rx done", 16'(rx_timing.frame_done), 16'(i % 11 == 10));
      chk("rx busy", 16'(rx_timing.busy), 16'(i % 11 != 10));
      if (i % 11 > 0) chk("rx period", 16'(t[i] - t[i - 1]), 16'h0028);
    end
    // Gap is the sender spacing less ten bits, so the latch offset repeats
    chk("rx restart", 16'(t[11] - t[10]), 16'h002c);
    @(posedge clk_sys);
    send <= 1'b0;
    rx_enable <= 1'b0;
  endtask : t_rx
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    power_on <= 1'b1;
    t_rates();
    t_frames();
    t_rx();
    tx_start <= 1'b1;
    repeat (40) @(posedge clk_sys);
    power_on <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk("powered off", 16'({base_tick, tx_timing.busy}), 16'h0000);
    results();
  end
endmodule : uart_baud_frame_timing_tb_top
